// ===== verilog/dither_engine.sv
// Dither engine end: 3x10-bit pixels in, 3x8-bit dithered pixels out.
// Assumes the link signals come from logic on the same clock.
`timescale 1ns/1ps
module dither_engine
#(
   parameter int DEPTH = dither_pkg::FIFO_DEPTH
)
(
   input  wire logic            i_clock,
   input  wire logic            i_resetn,
   input  wire logic            i_enable,
   input  wire logic            i_dither_mode_bit0,
   input  wire logic            i_dither_mode_bit1,
   pixel_link_if.dither_engine  link,
   input  wire logic            i_out_ready,
   output logic                 o_out_rgb24_valid,
   output logic [23:0]          o_out_rgb24,
   output logic                 o_fifo_ready
);
   dither_pkg::dither_mode_t mode;
   logic        col_r, col_nxt, row_r, row_nxt, lv_d_r, lv_d_nxt, fa_d_r, fa_d_nxt;
   logic        lpair_r, lpair_nxt;
   logic [1:0]  rot_r, rot_nxt;
   logic [15:0] lfsr_r, lfsr_nxt;
   logic [23:0] res_r, res_nxt;
   logic        rdy_r, rdy_nxt;
   logic [1:0]  idx, thr;
   logic [23:0] dith;
   logic        fifo_ready, take, line_end;
   logic [1:0]  mode_meta_r, mode_meta_nxt, mode_sync_r, mode_sync_nxt;

   // Mode pins come from push buttons, so two flops settle them before use
   assign mode = dither_pkg::dither_mode_t'(mode_sync_r);
   // A new pixel is only taken inside an active line
   assign take     = link.in_pixel_strobe && link.in_line_valid && link.frame_active;
   assign line_end = lv_d_r && !link.in_line_valid;

   // Position in the 2x2 tile, then rotation offset
   always_comb
   begin
      idx = {row_r, col_r};
      if (mode != dither_pkg::MODE_SPATIAL)
      begin
         idx = 2'(idx + rot_r);
      end
      thr = idx;
   end

   generate
      for (genvar c = 0; c < 3; c++)
      begin : g_comp
         logic [7:0] hi;
         logic [1:0] err;
         logic [7:0] sum;
         assign hi  = link.in_rgb30[c*dither_pkg::IN_COMP+dither_pkg::ERR_BITS +: 8];
         assign err = link.in_rgb30[c*dither_pkg::IN_COMP +: 2];
         always_comb
         begin
            sum = hi;
            if (mode != dither_pkg::MODE_OFF && err > thr && hi != dither_pkg::COMP_MAX)
            begin
               sum = 8'(hi + 8'h01);
            end
         end
         assign dith[c*8 +: 8] = sum;
      end
   endgenerate

   always_comb
   begin
      col_nxt   = col_r;
      row_nxt   = row_r;
      lpair_nxt = lpair_r;
      rot_nxt   = rot_r;
      lv_d_nxt  = link.in_line_valid;
      fa_d_nxt  = link.frame_active;
      lfsr_nxt  = lfsr_r;
      res_nxt   = res_r;
      rdy_nxt   = 1'b0;
      // Bit 1 is the high bit of the selection
      mode_meta_nxt = {i_dither_mode_bit1, i_dither_mode_bit0};
      mode_sync_nxt = mode_meta_r;
      if (take)
      begin
         col_nxt = !col_r;
         res_nxt = dith;
         rdy_nxt = 1'b1;
         // Random weights step once per pixel for an unrepeating pattern
         lfsr_nxt = lfsr_r[0] ? ((lfsr_r >> 1) ^ dither_pkg::LFSR_TAPS) : (lfsr_r >> 1);
      end
      if (line_end)
      begin
         col_nxt   = 1'b0;
         row_nxt   = !row_r;
         lpair_nxt = !lpair_r;
         if (mode == dither_pkg::MODE_TEMPO && lpair_r)
         begin
            rot_nxt = 2'(rot_r + 2'h1);
         end
      end
      if (fa_d_r && !link.frame_active)
      begin
         col_nxt   = 1'b0;
         row_nxt   = 1'b0;
         lpair_nxt = 1'b0;
         if (mode == dither_pkg::MODE_TEMPO)
         begin
            rot_nxt = 2'(rot_r + 2'h1);
         end
      end
      if (mode == dither_pkg::MODE_RANDOM)
      begin
         rot_nxt = lfsr_r[1:0];
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         col_r   <= 1'b0;
         row_r   <= 1'b0;
         lpair_r <= 1'b0;
         rot_r   <= 2'h0;
         lv_d_r  <= 1'b0;
         fa_d_r  <= 1'b0;
         lfsr_r  <= dither_pkg::LFSR_SEED;
         res_r   <= '0;
         rdy_r   <= 1'b0;
         mode_meta_r <= 2'h0;
         mode_sync_r <= 2'h0;
      end
      else if (i_enable)
      begin
         col_r   <= col_nxt;
         row_r   <= row_nxt;
         lpair_r <= lpair_nxt;
         rot_r   <= rot_nxt;
         lv_d_r  <= lv_d_nxt;
         fa_d_r  <= fa_d_nxt;
         lfsr_r  <= lfsr_nxt;
         res_r   <= res_nxt;
         rdy_r   <= rdy_nxt;
         mode_meta_r <= mode_meta_nxt;
         mode_sync_r <= mode_sync_nxt;
      end
   end

   // Upstream cannot be stalled, so a full FIFO drops pixels; o_fifo_ready shows it
   logic        f_valid;
   logic [23:0] f_data;
   pixel_fifo #(.WIDTH(dither_pkg::OUT_WIDTH), .DEPTH(DEPTH)) u_fifo
   (
      .i_clock  (i_clock),
      .i_resetn (i_resetn),
      .i_enable (i_enable),
      .i_valid  (rdy_r),
      .o_ready  (fifo_ready),
      .i_data   (res_r),
      .o_valid  (f_valid),
      .i_ready  (i_out_ready && (!o_out_rgb24_valid || i_out_ready)),
      .o_data   (f_data)
   );

   logic        ov_nxt, fr_nxt;
   logic [23:0] od_nxt;
   always_comb
   begin
      ov_nxt = o_out_rgb24_valid;
      od_nxt = o_out_rgb24;
      fr_nxt = fifo_ready;
      if (i_out_ready || !o_out_rgb24_valid)
      begin
         ov_nxt = f_valid && i_out_ready;
         od_nxt = f_valid && i_out_ready ? f_data : o_out_rgb24;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_out_rgb24_valid <= 1'b0;
         o_out_rgb24       <= '0;
         o_fifo_ready      <= 1'b0;
      end
      else if (i_enable)
      begin
         o_out_rgb24_valid <= ov_nxt;
         o_out_rgb24       <= od_nxt;
         o_fifo_ready      <= fr_nxt;
      end
   end
endmodule // dither_engine

// ===== verilog/dither_pkg.sv
// Shared constants and types for the 10-to-8 bit pixel dither link.
// Assumes both ends and the interface compile after this package.
package dither_pkg;
   localparam int IN_WIDTH      = 30;
   localparam int OUT_WIDTH     = 24;
   localparam int IN_COMP       = 10;
   localparam int OUT_COMP      = 8;
   localparam int ERR_BITS      = 2;
   localparam int FIFO_DEPTH    = 16;
   localparam int ROT_LINES     = 2;
   localparam logic [15:0] LFSR_SEED = 16'hace1;
   localparam logic [15:0] LFSR_TAPS = 16'hb400;
   localparam logic [7:0]  COMP_MAX  = 8'hff;
   typedef enum logic [1:0]
   {
      MODE_OFF,
      MODE_SPATIAL,
      MODE_TEMPO,
      MODE_RANDOM
   } dither_mode_t;
endpackage

// ===== verilog/pixel_link_if.sv
// Interface joining the gamma side to the dither engine.
// Assumes one clock; the testbench drives the clock and reset.
`timescale 1ns/1ps
interface pixel_link_if;
   logic        in_line_valid;
   logic        in_pixel_strobe;
   logic [29:0] in_rgb30;
   logic        frame_active;
   modport gamma_stage
   (
      output in_line_valid,
      output in_pixel_strobe,
      output in_rgb30,
      output frame_active
   );
   modport dither_engine
   (
      input in_line_valid,
      input in_pixel_strobe,
      input in_rgb30,
      input frame_active
   );
endinterface

// ===== verilog/pixel_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock shared by writer and reader.
`timescale 1ns/1ps
module pixel_fifo
#(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
)
(
   input  wire logic             i_clock,
   input  wire logic             i_resetn,
   input  wire logic             i_enable,
   input  wire logic             i_valid,
   output logic                  o_ready,
   input  wire logic [WIDTH-1:0] i_data,
   output logic                  o_valid,
   input  wire logic             i_ready,
   output logic      [WIDTH-1:0] o_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
   logic [AW:0]      cnt_r, cnt_nxt;
   logic             push, pop;

   assign o_ready = (cnt_r != (AW+1)'(DEPTH));
   assign o_valid = (cnt_r != '0);
   assign o_data  = mem[rd_r];
   assign push    = i_enable && i_valid && o_ready;
   assign pop     = i_enable && o_valid && i_ready;

   always_comb
   begin
      wr_nxt  = push ? AW'(wr_r + 1'b1) : wr_r;
      rd_nxt  = pop ? AW'(rd_r + 1'b1) : rd_r;
      cnt_nxt = (AW+1)'(cnt_r + {AW'(0), push} - {AW'(0), pop});
   end

   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         wr_r  <= wr_nxt;
         rd_r  <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Storage carries no reset so it can map to RAM
   always_ff @(posedge i_clock)
   begin
      if (push)
      begin
         mem[wr_r] <= i_data;
      end
   end
endmodule // pixel_fifo

// ===== verilog/gamma_stage_end.sv
// Upstream end: turns user pixels into line-valid, strobe and 30-bit data.
// Assumes the user holds i_pixel_valid until o_pixel_ready accepts it.
`timescale 1ns/1ps
module gamma_stage_end
(
   input  wire logic          i_clock,
   input  wire logic          i_resetn,
   input  wire logic          i_enable,
   input  wire logic          i_frame,
   input  wire logic          i_line,
   input  wire logic          i_pixel_valid,
   input  wire logic [29:0]   i_pixel,
   output logic               o_pixel_ready,
   pixel_link_if.gamma_stage  link
);
   logic        line_r, line_nxt, frame_r, frame_nxt, stb_r, stb_nxt;
   logic [29:0] pix_r, pix_nxt;

   always_comb
   begin
      line_nxt  = i_line;
      frame_nxt = i_frame;
      stb_nxt   = 1'b0;
      pix_nxt   = pix_r;
      if (i_line && i_pixel_valid && !stb_r)
      begin
         stb_nxt = 1'b1;
         pix_nxt = i_pixel;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         line_r  <= 1'b0;
         frame_r <= 1'b0;
         stb_r   <= 1'b0;
         pix_r   <= '0;
      end
      else if (i_enable)
      begin
         line_r  <= line_nxt;
         frame_r <= frame_nxt;
         stb_r   <= stb_nxt;
         pix_r   <= pix_nxt;
      end
   end

   // Strobe is never two cycles in a row, so each pixel is one pulse
   assign o_pixel_ready         = i_enable && i_line && !stb_r;
   assign link.in_line_valid    = line_r;
   assign link.frame_active     = frame_r;
   assign link.in_pixel_strobe  = stb_r;
   assign link.in_rgb30         = pix_r;
endmodule // gamma_stage_end

// ===== tb/pixel_link_chk.sv
// Assertions on the pixel link and on the engine output.
// Assumes one clock; the bench instantiates it beside the link.
`timescale 1ns/1ps
module pixel_link_chk
(
   input wire logic        i_clock,
   input wire logic        i_resetn,
   input wire logic        i_line,
   input wire logic        i_frame,
   input wire logic        i_pixel_valid,
   input wire logic        o_pixel_ready,
   input wire logic [29:0] i_pixel,
   input wire logic        in_line_valid,
   input wire logic        in_pixel_strobe,
   input wire logic [29:0] in_rgb30,
   input wire logic        frame_active,
   input wire logic        i_out_ready,
   input wire logic        o_out_rgb24_valid,
   input wire logic [23:0] o_out_rgb24
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   a_line_follows: assert property (in_line_valid == $past(i_line))
      else $error("line valid lag wrong");
   a_frame_follows: assert property (frame_active == $past(i_frame))
      else $error("frame active lag wrong");
   a_strobe_single: assert property (in_pixel_strobe |=> !in_pixel_strobe)
      else $error("strobe longer than one cycle");
   a_strobe_caused: assert property
      (in_pixel_strobe |-> $past(i_pixel_valid) && $past(o_pixel_ready))
      else $error("strobe without pixel");
   a_pixel_carried: assert property
      (i_pixel_valid && o_pixel_ready |=> in_rgb30 == $past(i_pixel))
      else $error("pixel word altered");
   a_strobe_in_line: assert property
      (in_pixel_strobe |-> in_line_valid && frame_active)
      else $error("strobe outside line");
   a_out_stands: assert property
      (o_out_rgb24_valid && !i_out_ready |=> o_out_rgb24_valid && $stable(o_out_rgb24))
      else $error("output dropped while stalled");
   a_out_on_ready: assert property ($rose(o_out_rgb24_valid) |-> $past(i_out_ready))
      else $error("output rose without ready");
   a_reset_quiet: assert property
      ($rose(i_resetn) |-> !o_out_rgb24_valid && !in_pixel_strobe)
      else $error("output busy after reset");
   c_take: cover property (in_pixel_strobe && in_line_valid);
   c_stall: cover property (o_out_rgb24_valid && !i_out_ready);
   c_line_end: cover property ($fell(in_line_valid));
endmodule // pixel_link_chk

// ===== tb/tb_pixel_dither_10to8.sv
// Bench: gamma end feeds the dither engine over the link.
// Assumes the package, interface and both ends compile first.
`timescale 1ns/1ps
module tb_pixel_dither_10to8;
   logic                     i_clock, i_resetn = 1'b0, i_frame = 1'b0, i_line = 1'b0;
   logic                     i_pixel_valid = 1'b0, i_out_ready = 1'b1, en = 1'b1;
   logic [15:0]              lfsr_m;
   logic                     o_pixel_ready, o_out_rgb24_valid, o_fifo_ready;
   logic [29:0]              i_pixel = 30'h0, p;
   logic [23:0]              o_out_rgb24;
   logic [23:0]              exp_q[$], got_q[$];
   dither_pkg::dither_mode_t mode = dither_pkg::MODE_OFF;
   int                       error_cnt = 0, comparisons = 0;
   pixel_link_if link ();
   gamma_stage_end gamma_stage_end_i (.i_clock, .i_resetn, .i_enable(en), .i_frame, .i_line,
      .i_pixel_valid, .i_pixel, .o_pixel_ready, .link(link.gamma_stage));
   dither_engine #(.DEPTH(dither_pkg::FIFO_DEPTH)) dither_engine_i (.i_clock, .i_resetn,
      .i_enable(en), .i_dither_mode_bit0(mode[0]), .i_dither_mode_bit1(mode[1]),
      .link(link.dither_engine), .i_out_ready, .o_out_rgb24_valid, .o_out_rgb24, .o_fifo_ready);
   pixel_link_chk pixel_link_chk_i (.i_clock, .i_resetn, .i_line, .i_frame, .i_pixel_valid,
      .o_pixel_ready, .i_pixel, .in_line_valid(link.in_line_valid), .i_out_ready,
      .in_pixel_strobe(link.in_pixel_strobe), .in_rgb30(link.in_rgb30),
      .frame_active(link.frame_active), .o_out_rgb24_valid, .o_out_rgb24);
   initial
   begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   always @(posedge i_clock)
      if (o_out_rgb24_valid === 1'b1 && i_out_ready === 1'b1)
         got_q.push_back(o_out_rgb24);
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [23:0] dith(input logic [29:0] px, input int thr);
      logic [7:0] u;
      for (int k = 0; k < 3; k++)
      begin
         u = px[k*10+2 +: 8];
         // Saturate rather than wrap: a wrapped white would flash black
         if (int'(px[k*10 +: 2]) > thr && u != 8'hff)
            u++;
         dith[k*8 +: 8] = u;
      end
   endfunction
   task automatic do_reset(input dither_pkg::dither_mode_t m);
      i_resetn <= 1'b0;
      mode     <= m;
      repeat (3) @(posedge i_clock);
      i_resetn <= 1'b1;
      exp_q.delete();
      got_q.delete();
      lfsr_m = dither_pkg::LFSR_SEED;
      @(posedge i_clock);
   endtask
   task automatic send_line(input int l, input int n, input logic [1:0] lo, input int m);
      i_line <= 1'b1;
      repeat (2) @(posedge i_clock);
      for (int c = 0; c < n; c++)
      begin
         int t;
         p = {8'(16*l+4*c), lo, 8'(16*l+4*c+1), lo, 8'(16*l+4*c+2), lo};
         if (l == 0 && c == 0)
            p[29:22] = 8'hff;
         // Random rotation follows the seeded LFSR, one step per pixel taken
         t = l%2*2 + c%2 + (m == 2 ? l/2 : 0) + (m == 3 ? int'(lfsr_m[1:0]) : 0);
         exp_q.push_back(dith(p, m == 0 ? 3 : t % 4));
         lfsr_m = lfsr_m[0] ? ((lfsr_m >> 1) ^ dither_pkg::LFSR_TAPS) : (lfsr_m >> 1);
         i_pixel_valid <= 1'b1;
         i_pixel       <= p;
         do @(negedge i_clock); while (o_pixel_ready !== 1'b1);
         @(posedge i_clock);
      end
      i_pixel_valid <= 1'b0;
      repeat (3) @(posedge i_clock);
      i_line <= 1'b0;
      repeat (3) @(posedge i_clock);
   endtask
   task automatic run_test(input string name, input dither_pkg::dither_mode_t m, input int lines,
                           input logic [1:0] lo);
      do_reset(m);
      i_frame <= 1'b1;
      repeat (2) @(posedge i_clock);
      for (int l = 0; l < lines; l++)
         send_line(l, 2, lo, int'(m));
      i_frame <= 1'b0;
      repeat (40) @(posedge i_clock);
      check("count", 24'(exp_q.size()), 24'(got_q.size()));
      foreach (got_q[i])
         check(name, exp_q[i], got_q[i]);
      $display("Test %s done", name);
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Tests need about four hundred cycles; ten thousand means a hang
   initial
   begin
      #400000;
      error_cnt++;
      give_verdict();
   end
   initial
   begin
      run_test("off", dither_pkg::MODE_OFF, 2, 2'd3);
      run_test("spatial", dither_pkg::MODE_SPATIAL, 2, 2'd1);
      run_test("tempo", dither_pkg::MODE_TEMPO, 4, 2'd1);
      run_test("random", dither_pkg::MODE_RANDOM, 2, 2'd3);
      // Stall the far side so the buffer fills and refuses
      do_reset(dither_pkg::MODE_OFF);
      i_out_ready <= 1'b0;
      i_frame     <= 1'b1;
      repeat (2) @(posedge i_clock);
      send_line(0, 20, 2'd3, 0);
      check("fifo full", 24'h0, 24'(o_fifo_ready));
      // Clock enable low must freeze both ends even with the far side ready
      en          <= 1'b0;
      i_out_ready <= 1'b1;
      repeat (4) @(posedge i_clock);
      check("frozen", 24'h0, 24'(o_out_rgb24_valid));
      en          <= 1'b1;
      i_out_ready <= 1'b1;
      repeat (3) @(posedge i_clock);
      i_out_ready <= 1'b0;
      repeat (3) @(posedge i_clock);
      i_out_ready <= 1'b1;
      repeat (40) @(posedge i_clock);
      check("fifo ready", 24'h1, 24'(o_fifo_ready));
      check("fifo count", 24'(dither_pkg::FIFO_DEPTH), 24'(got_q.size()));
      for (int i = 0; i < dither_pkg::FIFO_DEPTH; i++)
         check("fifo", exp_q[i], got_q[i]);
      i_frame <= 1'b0;
      $display("Test fifo done");
      give_verdict();
   end
endmodule // tb_pixel_dither_10to8
